// ---- hw/atto_pkg.sv ----
package atto_pkg;
	localparam int CH_MAX = 2;
	localparam int DATA_W = 12;
	// register pointers, one entry per channel
	localparam logic [7:0] ADDR_AVG_HI  [CH_MAX] = '{8'h05, 8'h07};
	localparam logic [7:0] ADDR_AVG_LO  [CH_MAX] = '{8'h06, 8'h08};
	localparam logic [7:0] ADDR_SENS    [CH_MAX] = '{8'h09, 8'h0c};
	localparam logic [7:0] ADDR_TIMEOUT [CH_MAX] = '{8'h0a, 8'h0d};
	localparam logic [7:0] ADDR_SETUP   [CH_MAX] = '{8'h0b, 8'h0e};
	// reset values
	localparam logic [7:0] SETUP_RST   = 8'h0b;
	localparam logic [7:0] TIMEOUT_RST = 8'h86;
	localparam logic [7:0] SENS_RST    = 8'h08;
	// setup fields
	localparam int SETUP_RANGE_LSB  = 6;
	localparam int SETUP_HYST       = 4;
	localparam int SETUP_SETTLE_LSB = 0;
	// timeout fields: approach exponent high nibble, recede low nibble
	localparam int TO_APR_LSB = 4;
	localparam int TO_REC_LSB = 0;
	// range code to input range in half-pF units, and to offset-DAC step
	localparam logic [3:0] RANGE_HALF_PF [4] = '{4'h4, 4'h1, 4'h2, 4'h8};
	localparam logic [3:0] DAC_STEP      [4] = '{4'h4, 4'h1, 4'h2, 4'h8};
	// comparator modes
	localparam logic [1:0] CMP_NEG    = 2'h0;
	localparam logic [1:0] CMP_POS    = 2'h1;
	localparam logic [1:0] CMP_WINDOW = 2'h2;
	typedef enum logic [2:0] {
		ATTO_IDLE     = 3'b001,
		ATTO_APPROACH = 3'b010,
		ATTO_RECEDE   = 3'b100
	} atto_state_t;
endpackage : atto_pkg

// ---- hw/atto_chan_if.sv ----
interface atto_chan_if;
	logic        conv_done;
	logic [11:0] conv_data;
	logic [11:0] avg;
	logic [7:0]  sens;
	logic [1:0]  cmp_mode;
	logic        adaptive;
	logic [7:0]  timeout;
	logic        expire;
	modport chan (
		input  conv_done, conv_data, avg, sens, cmp_mode, adaptive, timeout,
		output expire
	);
	modport top (
		output conv_done, conv_data, avg, sens, cmp_mode, adaptive, timeout,
		input  expire
	);
endinterface : atto_chan_if

// ---- hw/atto_chan.sv ----
module atto_chan (
	input wire logic  clk,
	input wire logic  srst,
	atto_chan_if.chan cif
);
	atto_pkg::atto_state_t state_ff, nxt_state;
	logic [15:0] cnt_ff, nxt_cnt;
	logic        expire_ff, nxt_expire;
	logic        above, below, toward, away, enabled;
	logic [16:0] new_cnt, apr_target, rec_target;

	// band crossing relative to the running average
	always_comb begin
		above = {1'b0, cif.conv_data} > ({1'b0, cif.avg} + {5'h00, cif.sens});
		below = ({1'b0, cif.conv_data} + {5'h00, cif.sens}) < {1'b0, cif.avg};
		toward = (cif.cmp_mode == atto_pkg::CMP_WINDOW) ? (above | below) :
			(cif.cmp_mode == atto_pkg::CMP_POS) ? above : below;
		away = (cif.cmp_mode == atto_pkg::CMP_POS) ? below :
			(cif.cmp_mode == atto_pkg::CMP_NEG) ? above : 1'b0;
		enabled = cif.adaptive && (cif.timeout != 8'h00);
		apr_target = 17'h00001 << cif.timeout[atto_pkg::TO_APR_LSB +: 4];
		rec_target = 17'h00001 << cif.timeout[atto_pkg::TO_REC_LSB +: 4];
	end

	// one step per finished conversion; a new crossing restarts the count
	always_comb begin
		nxt_state = state_ff;
		nxt_cnt = cnt_ff;
		nxt_expire = 1'b0;
		new_cnt = 17'h00001;
		if (cif.conv_done) begin
			if (!enabled) begin
				nxt_state = atto_pkg::ATTO_IDLE;
				nxt_cnt = 16'h0000;
			end else if (toward) begin
				if (state_ff == atto_pkg::ATTO_APPROACH)
					new_cnt = {1'b0, cnt_ff} + 17'h00001;
				nxt_state = atto_pkg::ATTO_APPROACH;
				nxt_cnt = new_cnt[15:0];
				if (new_cnt == apr_target) begin
					nxt_expire = 1'b1;
					nxt_state = atto_pkg::ATTO_IDLE;
					nxt_cnt = 16'h0000;
				end
			end else if (away) begin
				if (state_ff == atto_pkg::ATTO_RECEDE)
					new_cnt = {1'b0, cnt_ff} + 17'h00001;
				nxt_state = atto_pkg::ATTO_RECEDE;
				nxt_cnt = new_cnt[15:0];
				if (new_cnt == rec_target) begin
					nxt_expire = 1'b1;
					nxt_state = atto_pkg::ATTO_IDLE;
					nxt_cnt = 16'h0000;
				end
			end else begin
				// back inside the band: nothing to time
				nxt_state = atto_pkg::ATTO_IDLE;
				nxt_cnt = 16'h0000;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			state_ff <= atto_pkg::ATTO_IDLE;
			cnt_ff <= 16'h0000;
			expire_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
			expire_ff <= nxt_expire;
		end
	end

	assign cif.expire = expire_ff;

	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	sequence s_live;
		cif.conv_done && enabled;
	endsequence
	sequence s_apr_start;
		s_live ##0 toward && state_ff != atto_pkg::ATTO_APPROACH;
	endsequence
	sequence s_rec_start;
		s_live ##0 away && !toward && state_ff != atto_pkg::ATTO_RECEDE;
	endsequence

	apr_start_a: assert property (s_apr_start ##0 apr_target != 17'h00001
		|=> state_ff == atto_pkg::ATTO_APPROACH && cnt_ff == 16'h0001)
		else $error("approach count did not start");
	apr_expire_a: assert property (s_live ##0 toward
		&& state_ff == atto_pkg::ATTO_APPROACH && {1'b0, cnt_ff} + 17'h00001 == apr_target
		|=> expire_ff ##1 !expire_ff)
		else $error("approach timeout missed");
	rec_start_a: assert property (s_rec_start ##0 rec_target != 17'h00001
		|=> state_ff == atto_pkg::ATTO_RECEDE && cnt_ff == 16'h0001)
		else $error("recede count did not start");
	window_no_rec_a: assert property (cif.cmp_mode == atto_pkg::CMP_WINDOW
		&& state_ff != atto_pkg::ATTO_RECEDE |=> state_ff != atto_pkg::ATTO_RECEDE)
		else $error("recede timing in window mode");
	rec_expire_a: assert property (s_live ##0 away && !toward
		&& state_ff == atto_pkg::ATTO_RECEDE && {1'b0, cnt_ff} + 17'h00001 == rec_target
		|=> expire_ff)
		else $error("recede timeout missed");
	zero_off_a: assert property (cif.conv_done && cif.timeout == 8'h00
		|=> !expire_ff && cnt_ff == 16'h0000)
		else $error("timeout active with zero register");
	fixed_off_a: assert property (cif.conv_done && !cif.adaptive
		|=> !expire_ff && state_ff == atto_pkg::ATTO_IDLE)
		else $error("timeout active in fixed mode");
	in_band_a: assert property (s_live ##0 !toward && !away
		|=> cnt_ff == 16'h0000 && state_ff == atto_pkg::ATTO_IDLE)
		else $error("count not restarted inside band");
endmodule : atto_chan

// ---- hw/atto_top.sv ----
// Overview of operation
// - In adaptive mode the approach count starts when data leaves the band toward the threshold.
// - The approach timeout expires after two to the approach exponent conversions.
// - The recede count starts when data leaves the band away from the threshold.
// - Window comparator mode never runs the recede timeout.
// - The recede timeout expires after two to the recede exponent conversions.
// - On expiry the average takes the newest conversion result at once.
// - A timeout register of zero disables both timeouts.
// - Timeouts act only in adaptive threshold mode.
// - Range code 00/01/10/11 selects 2, 0.5, 1 and 4 pF.
// - The same code selects offset-DAC steps of 4, 1, 2 and 8.
// - Each setup register is read/write and resets to 0x0b.
// - Expiry overwrites the average and drops its history.
// - Thresholds sit one sensitivity above and below the average.
module atto_top #(
	parameter int CHANNELS = 2
) (
	input  wire logic                       clk,
	input  wire logic                       srst,
	input  wire logic [CHANNELS-1:0]        conv_done,
	input  wire logic [CHANNELS-1:0][11:0]  conv_data,
	input  wire logic [CHANNELS-1:0][11:0]  avg_filter_in,
	input  wire logic                       adaptive_mode,
	input  wire logic [1:0]                 cmp_mode,
	input  wire logic [7:0]                 reg_addr,
	input  wire logic                       reg_wr_en,
	input  wire logic [7:0]                 reg_wr_data,
	input  wire logic                       reg_rd_en,
	output logic      [7:0]                 reg_rd_data_ff,
	output logic      [CHANNELS-1:0][11:0]  avg_ff,
	output logic      [CHANNELS-1:0][12:0]  thr_pos_ff,
	output logic      [CHANNELS-1:0][11:0]  thr_neg_ff,
	output logic      [CHANNELS-1:0][3:0]   input_range_ff,
	output logic      [CHANNELS-1:0][3:0]   dac_step_ff,
	output logic      [CHANNELS-1:0][3:0]   settling_code_ff,
	output logic      [CHANNELS-1:0]        hyst_ff,
	output logic      [CHANNELS-1:0]        timeout_event_ff
);
	// refuse channel counts that the register map cannot serve
	if (CHANNELS < 1 || CHANNELS > atto_pkg::CH_MAX) begin : g_bad_channels
		$error("CHANNELS must be 1 or 2");
	end

	// shadow registers, conversion capture and next values of the outputs
	logic [7:0]  setup_ff    [CHANNELS];
	logic [7:0]  nxt_setup   [CHANNELS];
	logic [7:0]  timeout_ff  [CHANNELS];
	logic [7:0]  nxt_timeout [CHANNELS];
	logic [7:0]  sens_ff     [CHANNELS];
	logic [7:0]  nxt_sens    [CHANNELS];
	logic [11:0] data_ff     [CHANNELS];
	logic [11:0] nxt_data    [CHANNELS];
	logic [11:0] filt_ff     [CHANNELS];
	logic [11:0] nxt_filt    [CHANNELS];
	logic [CHANNELS-1:0]       pend_ff;
	logic [CHANNELS-1:0]       nxt_pend;
	logic [CHANNELS-1:0]       chan_expire;
	logic [CHANNELS-1:0][11:0] nxt_avg;
	logic [CHANNELS-1:0][12:0] nxt_thr_pos;
	logic [CHANNELS-1:0][11:0] nxt_thr_neg;
	logic [CHANNELS-1:0][3:0]  nxt_range;
	logic [CHANNELS-1:0][3:0]  nxt_step;
	logic [CHANNELS-1:0][3:0]  nxt_settle;
	logic [CHANNELS-1:0]       nxt_hyst;
	logic [7:0]                nxt_rd_data;
	logic [1:0]                rng;

	// per-channel timeout engines
	for (genvar g = 0; g < CHANNELS; g++) begin : g_chan
		atto_chan_if cif ();
		assign cif.conv_done = conv_done[g];
		assign cif.conv_data = conv_data[g];
		assign cif.avg = avg_ff[g];
		assign cif.sens = sens_ff[g];
		assign cif.cmp_mode = cmp_mode;
		assign cif.adaptive = adaptive_mode;
		assign cif.timeout = timeout_ff[g];
		assign chan_expire[g] = cif.expire;
		atto_chan u_chan (
			.clk  (clk),
			.srst (srst),
			.cif  (cif.chan)
		);
	end

	// register writes and the average update; the average lands one cycle after
	// the conversion so the engine's expiry decision can steer it
	always_comb begin
		rng = 2'h0;
		for (int c = 0; c < CHANNELS; c++) begin
			nxt_setup[c] = setup_ff[c];
			nxt_timeout[c] = timeout_ff[c];
			nxt_sens[c] = sens_ff[c];
			if (reg_wr_en) begin
				if (reg_addr == atto_pkg::ADDR_SETUP[c])
					nxt_setup[c] = reg_wr_data;
				else if (reg_addr == atto_pkg::ADDR_TIMEOUT[c])
					nxt_timeout[c] = reg_wr_data;
				else if (reg_addr == atto_pkg::ADDR_SENS[c])
					nxt_sens[c] = reg_wr_data;
			end
			nxt_pend[c] = conv_done[c];
			nxt_data[c] = conv_done[c] ? conv_data[c] : data_ff[c];
			nxt_filt[c] = conv_done[c] ? avg_filter_in[c] : filt_ff[c];
			nxt_avg[c] = avg_ff[c];
			if (pend_ff[c])
				nxt_avg[c] = chan_expire[c] ? data_ff[c] : filt_ff[c];
			// thresholds follow the average; the lower one clamps at zero
			nxt_thr_pos[c] = {1'b0, avg_ff[c]} + {5'h00, sens_ff[c]};
			nxt_thr_neg[c] = (avg_ff[c] > {4'h0, sens_ff[c]}) ?
				avg_ff[c] - {4'h0, sens_ff[c]} : 12'h000;
			// bit 5 is stored as written but steers nothing
			rng = setup_ff[c][atto_pkg::SETUP_RANGE_LSB +: 2];
			nxt_range[c] = atto_pkg::RANGE_HALF_PF[rng];
			nxt_step[c] = atto_pkg::DAC_STEP[rng];
			nxt_settle[c] = setup_ff[c][atto_pkg::SETUP_SETTLE_LSB +: 4];
			nxt_hyst[c] = setup_ff[c][atto_pkg::SETUP_HYST];
		end
	end

	// read port: data stands the cycle after the request, zero when unmapped
	always_comb begin
		nxt_rd_data = 8'h00;
		if (reg_rd_en) begin
			for (int c = 0; c < CHANNELS; c++) begin
				if (reg_addr == atto_pkg::ADDR_SETUP[c])
					nxt_rd_data = setup_ff[c];
				else if (reg_addr == atto_pkg::ADDR_TIMEOUT[c])
					nxt_rd_data = timeout_ff[c];
				else if (reg_addr == atto_pkg::ADDR_SENS[c])
					nxt_rd_data = sens_ff[c];
				else if (reg_addr == atto_pkg::ADDR_AVG_HI[c])
					nxt_rd_data = avg_ff[c][11:4];
				else if (reg_addr == atto_pkg::ADDR_AVG_LO[c])
					nxt_rd_data = {avg_ff[c][3:0], 4'h0};
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			for (int c = 0; c < CHANNELS; c++) begin
				setup_ff[c] <= atto_pkg::SETUP_RST;
				timeout_ff[c] <= atto_pkg::TIMEOUT_RST;
				sens_ff[c] <= atto_pkg::SENS_RST;
				data_ff[c] <= 12'h000;
				filt_ff[c] <= 12'h000;
			end
			pend_ff <= '0;
			avg_ff <= '0;
			thr_pos_ff <= '0;
			thr_neg_ff <= '0;
			input_range_ff <= '0;
			dac_step_ff <= '0;
			settling_code_ff <= '0;
			hyst_ff <= '0;
			timeout_event_ff <= '0;
			reg_rd_data_ff <= 8'h00;
		end else begin
			setup_ff <= nxt_setup;
			timeout_ff <= nxt_timeout;
			sens_ff <= nxt_sens;
			data_ff <= nxt_data;
			filt_ff <= nxt_filt;
			pend_ff <= nxt_pend;
			avg_ff <= nxt_avg;
			thr_pos_ff <= nxt_thr_pos;
			thr_neg_ff <= nxt_thr_neg;
			input_range_ff <= nxt_range;
			dac_step_ff <= nxt_step;
			settling_code_ff <= nxt_settle;
			hyst_ff <= nxt_hyst;
			timeout_event_ff <= chan_expire;
			reg_rd_data_ff <= nxt_rd_data;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	setup_rst_a: assert property ($fell(srst) |-> setup_ff[0] == atto_pkg::SETUP_RST
		&& timeout_ff[0] == atto_pkg::TIMEOUT_RST)
		else $error("setup reset value wrong");
	avg_load_a: assert property (pend_ff[0] && chan_expire[0]
		|=> avg_ff[0] == $past(data_ff[0]) ##1 timeout_event_ff[0] == 1'b0)
		else $error("average not loaded on expiry");
	avg_hist_a: assert property (conv_done[0] ##1 !chan_expire[0]
		|=> avg_ff[0] == $past(filt_ff[0]))
		else $error("filtered average not taken");
	thr_band_a: assert property (!srst && $stable(avg_ff[0]) && $stable(sens_ff[0])
		|=> thr_pos_ff[0] == {1'b0, $past(avg_ff[0])} + {5'h00, $past(sens_ff[0])})
		else $error("upper threshold off the band");
	range_map_a: assert property (setup_ff[0][7:6] == 2'h3 && $stable(setup_ff[0])
		|=> input_range_ff[0] == atto_pkg::RANGE_HALF_PF[3])
		else $error("range decode wrong");
	step_map_a: assert property (setup_ff[0][7:6] == 2'h1 && $stable(setup_ff[0])
		|=> dac_step_ff[0] == atto_pkg::DAC_STEP[1])
		else $error("offset-DAC step decode wrong");

	// register port: writes land at the next edge, reads return the old value
	setup_wr_a: assert property (reg_wr_en && reg_addr == atto_pkg::ADDR_SETUP[0]
		|=> setup_ff[0] == $past(reg_wr_data))
		else $error("setup write lost");
	setup_rd_a: assert property (reg_rd_en && reg_addr == atto_pkg::ADDR_SETUP[0]
		|=> reg_rd_data_ff == $past(setup_ff[0]))
		else $error("setup read wrong");
	timeout_wr_a: assert property (reg_wr_en && reg_addr == atto_pkg::ADDR_TIMEOUT[0]
		|=> timeout_ff[0] == $past(reg_wr_data))
		else $error("timeout write lost");
	rd_idle_a: assert property (!reg_rd_en |=> reg_rd_data_ff == 8'h00)
		else $error("read data stands too long");

	// the lower threshold never wraps while the average sits above the sensitivity
	thr_neg_a: assert property (avg_ff[0] > {4'h0, sens_ff[0]}
		|=> thr_neg_ff[0] + {4'h0, $past(sens_ff[0])} == $past(avg_ff[0]))
		else $error("lower threshold off the band");
	event_out_a: assert property (chan_expire[0] |=> timeout_event_ff[0])
		else $error("timeout event not raised");
endmodule : atto_top

// ---- test/adaptive_threshold_timeout_tb.sv ----
module adaptive_threshold_timeout_tb;
	timeunit 1ns;
	timeprecision 100ps;

	logic             clk = 1'b0;
	logic             srst = 1'b1;
	logic [1:0]       conv_done = '0;
	logic [1:0][11:0] conv_data = '0;
	logic [1:0][11:0] avg_filter_in = '0;
	logic             adaptive_mode = 1'b1;
	logic [1:0]       cmp_mode = 2'h1;
	logic [7:0]       reg_addr = 8'h00;
	logic             reg_wr_en = 1'b0;
	logic [7:0]       reg_wr_data = 8'h00;
	logic             reg_rd_en = 1'b0;
	logic [7:0]       reg_rd_data_ff;
	logic [1:0][11:0] avg_ff;
	logic [1:0][12:0] thr_pos_ff;
	logic [1:0][11:0] thr_neg_ff;
	logic [1:0][3:0]  input_range_ff;
	logic [1:0][3:0]  dac_step_ff;
	logic [1:0][3:0]  settling_code_ff;
	logic [1:0]       hyst_ff;
	logic [1:0]       timeout_event_ff;
	int               mismatches = 0;
	int               checks_done = 0;

	atto_top #(.CHANNELS(2)) atto_top_inst (
		.clk(clk), .srst(srst), .conv_done(conv_done), .conv_data(conv_data),
		.avg_filter_in(avg_filter_in), .adaptive_mode(adaptive_mode), .cmp_mode(cmp_mode),
		.reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data),
		.reg_rd_en(reg_rd_en), .reg_rd_data_ff(reg_rd_data_ff), .avg_ff(avg_ff),
		.thr_pos_ff(thr_pos_ff), .thr_neg_ff(thr_neg_ff), .input_range_ff(input_range_ff),
		.dac_step_ff(dac_step_ff), .settling_code_ff(settling_code_ff), .hyst_ff(hyst_ff),
		.timeout_event_ff(timeout_event_ff)
	);

	// 4 ns clock
	always #2 clk = ~clk;

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic results();
		$display("checks=%0d mismatches=%0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : results

	// one write strobe, taken at the next edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wr_data <= d;
		reg_wr_en <= 1'b1;
		@(posedge clk);
		reg_wr_en <= 1'b0;
	endtask : wr

	// read data stands only in the cycle after the taking edge
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		reg_addr <= a;
		reg_rd_en <= 1'b1;
		@(posedge clk);
		reg_rd_en <= 1'b0;
		#1;
		chk(16'(reg_rd_data_ff), 16'(exp));
	endtask : rd

	// one conversion; event and average land one edge after the taking edge,
	// and the event stands for that one cycle only
	task automatic conv(input int ch, input logic [11:0] data, input logic [11:0] filt,
			input logic hit);
		@(posedge clk);
		conv_done[ch] <= 1'b1;
		conv_data[ch] <= data;
		avg_filter_in[ch] <= filt;
		@(posedge clk);
		conv_done[ch] <= 1'b0;
		@(posedge clk);
		#1;
		chk(16'(timeout_event_ff[ch]), 16'(hit));
		chk(16'(avg_ff[ch]), hit ? 16'(data) : 16'(filt));
	endtask : conv

	// preset values, and silence from an unmapped pointer
	task automatic sc_reset_values();
		logic [7:0] ra [6] = '{8'h0b, 8'h0e, 8'h0a, 8'h0d, 8'h09, 8'h10};
		logic [7:0] rv [6] = '{8'h0b, 8'h0b, 8'h86, 8'h86, 8'h08, 8'h00};
		for (int i = 0; i < 6; i++) begin
			rd(ra[i], rv[i]);
		end
	endtask : sc_reset_values

	// every range code, with its range, dac step and the other setup fields
	task automatic sc_range();
		logic [3:0] half [4] = '{4'h4, 4'h1, 4'h2, 4'h8};
		logic [3:0] step [4] = '{4'h4, 4'h1, 4'h2, 4'h8};
		for (int c = 0; c < 4; c++) begin
			wr(8'h0b, {2'(c), 6'h1a});
			repeat (3) @(posedge clk);
			#1;
			chk(16'(input_range_ff[0]), 16'(half[c]));
			chk(16'(dac_step_ff[0]), 16'(step[c]));
			chk(16'(settling_code_ff[0]), 16'h000a);
			chk(16'(hyst_ff[0]), 16'h0001);
			rd(8'h0b, {2'(c), 6'h1a});
		end
		wr(8'h0e, 8'hcb);
		rd(8'h0e, 8'hcb);
	endtask : sc_range

	// approach count of four, broken once by an in-band result
	task automatic sc_approach();
		wr(8'h0a, 8'h20);
		conv(0, 12'h100, 12'h000, 1'b0);
		conv(0, 12'h100, 12'h000, 1'b0);
		conv(0, 12'h004, 12'h000, 1'b0);
		for (int i = 0; i < 3; i++) begin
			conv(0, 12'h100, 12'h000, 1'b0);
		end
		conv(0, 12'h100, 12'h000, 1'b1);
		@(posedge clk);
		#1;
		chk(16'(thr_pos_ff[0]), 16'h0108);
		chk(16'(thr_neg_ff[0]), 16'h00f8);
	endtask : sc_approach

	// recede count of two in positive mode, then none in window mode
	task automatic sc_recede();
		wr(8'h0a, 8'h01);
		conv(0, 12'h010, 12'h100, 1'b0);
		conv(0, 12'h010, 12'h100, 1'b1);
		wr(8'h0a, 8'hf1);
		cmp_mode <= 2'h2;
		for (int i = 0; i < 3; i++) begin
			conv(0, 12'h000, 12'h010, 1'b0);
		end
		@(posedge clk);
		cmp_mode <= 2'h1;
	endtask : sc_recede

	// zero register and fixed mode both keep the timeouts quiet
	task automatic sc_disabled();
		wr(8'h0a, 8'h00);
		for (int i = 0; i < 3; i++) begin
			conv(0, 12'h300, 12'h010, 1'b0);
		end
		wr(8'h0a, 8'h01);
		adaptive_mode <= 1'b0;
		conv(0, 12'h300, 12'h010, 1'b0);
		@(posedge clk);
		adaptive_mode <= 1'b1;
		conv(0, 12'h300, 12'h010, 1'b1);
	endtask : sc_disabled

	// an in-band result on one channel must not clear the other's count
	task automatic sc_channels();
		wr(8'h0a, 8'h11);
		wr(8'h0d, 8'h11);
		conv(0, 12'h000, 12'h300, 1'b0);
		conv(1, 12'h004, 12'h000, 1'b0);
		conv(0, 12'h000, 12'h300, 1'b1);
	endtask : sc_channels

	// hang guard
	initial begin
		repeat (100000) @(posedge clk);
		mismatches++;
		results();
	end

	initial begin
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		sc_reset_values();
		sc_range();
		sc_approach();
		sc_recede();
		sc_disabled();
		sc_channels();
		results();
	end
endmodule : adaptive_threshold_timeout_tb
